// >>> logic/acbs_regs.vh
// constants for the automatic command block sequencer
`ifndef ACBS_REGS_VH
`define ACBS_REGS_VH
// apb register byte offsets
`define ACBS_CTRL_OFF    12'h000
`define ACBS_STAT_OFF    12'h004
`define ACBS_CNT_OFF     12'h008
`define ACBS_LEN_OFF     12'h00C
// control fields
`define ACBS_CTRL_EN     0
`define ACBS_CTRL_RST    32'h0000_0000
// work queue offsets from the engine or media unit base
`define ACBS_SIE_OUT_Q   12'h190
`define ACBS_SIE_IN_Q    12'h194
`define ACBS_MDU_RD_Q    12'h010
`define ACBS_MDU_WR_Q    12'h014
// queue element fields
`define ACBS_QE_LAST     8'h80
// lookup table entries
`define ACBS_E_CBW       3'h0
`define ACBS_E_BUFA      3'h1
`define ACBS_E_BUFB      3'h2
`define ACBS_E_BUFC      3'h3
`define ACBS_E_CSW       3'h4
`define ACBS_E_DUP       3'h5
// completion targets
`define ACBS_T_SIE2      2'h0
`define ACBS_T_MDU0      2'h1
`define ACBS_T_MDU1      2'h2
// internal wrapper memory
`define ACBS_MEM_BASE    24'h00_F400
`define ACBS_CBW_LEN     6'h20
`define ACBS_CBW_MAX     6'h1F
`define ACBS_CSW_IDX     6'h20
`define ACBS_CSW_SIG     32'h5342_5355
// transfer unit and buffer counts
`define ACBS_UNIT        32'h0000_0200
`define ACBS_UNIT_SH     9
`define ACBS_NBUF        2'h3
`endif

// >>> logic/acbs_seq.v
// automatic command block sequencer with apb control
`timescale 1ns/1ps
`include "acbs_regs.vh"

// Contract
// - keep two buffers posted on engine out queue
// - wrappers live in internal media memory
// - element low bits entry, bit 7 last
// - out queue posts go to offset 0x190
// - command entry completes at media endpoint 1
// - also post spare element 0x5 there
// - lookup holds duplicate buffer, other target
// - oversize command sets overrun and halts
// - completion context locates the command wrapper
// - decode command, load endpoint byte count
// - out: repost duplicate, post remaining buffers
// - fewer buffers under three sectors
// - filled buffers become media endpoint 0 requests
// - consumption reduces count, zero disables
// - disabled endpoint drops requests, no completions
// - in: purge out queue to reclaim buffer
// - in: post buffers to media write queue
// - status after zero count and card ack
// - in status queued without waiting for data (here it waits for zero count and card ack like out)
// - status completion ends, restart with command
module acbs_seq (
    input  wire        i_clk,
    input  wire        i_sys_rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        i_cn_valid,
    input  wire [7:0]  i_cn_ctx,
    input  wire        i_cn_overrun,
    input  wire        i_mem_wr,
    input  wire [5:0]  i_mem_addr,
    input  wire [7:0]  i_mem_wdata,
    output reg  [7:0]  o_mem_rdata,
    input  wire        i_ep0_req,
    input  wire [7:0]  i_ep0_ctx,
    input  wire        i_card_ack,
    output reg         o_wq_valid,
    output reg  [11:0] o_wq_addr,
    output reg  [7:0]  o_wq_data,
    output reg         o_flush,
    output reg  [11:0] o_flush_addr,
    output reg         o_ep0_cn_valid,
    output reg  [7:0]  o_ep0_cn_ctx,
    output reg         o_error
);

// ****************************************
// states
// ****************************************
localparam S_IDLE  = 11'h001;
localparam S_PCBW  = 11'h002;
localparam S_WCBW  = 11'h004;
localparam S_DEC   = 11'h008;
localparam S_ODUP  = 11'h010;
localparam S_OPOST = 11'h020;
localparam S_IFL   = 11'h040;
localparam S_IPOST = 11'h080;
localparam S_WDONE = 11'h100;
localparam S_WCSW  = 11'h200;
localparam S_ERR   = 11'h400;

reg  [10:0] state_reg;
reg  [31:0] ctrl_reg;
reg  [31:0] cnt_reg;
reg  [31:0] len_reg;
reg         dir_in_reg;
reg         ack_reg;
reg         ovr_reg;
reg  [1:0]  nbuf_reg;
reg  [1:0]  idx_reg;
reg  [5:0]  cw_reg;
reg         cw_busy_reg;
reg  [7:0]  mem [0:63];

wire        en       = ctrl_reg[`ACBS_CTRL_EN];
wire        ep_on    = (cnt_reg != 32'h0000_0000);
wire        apb_acc  = psel & penable & ~pready;
wire [31:0] len_w    = {mem[11], mem[10], mem[9], mem[8]};
wire [31:0] sect_w   = (len_w + `ACBS_UNIT - 32'h0000_0001) >> `ACBS_UNIT_SH;

// ****************************************
// lookup table targets
// ****************************************
// entry 5 shares buffer a but completes to endpoint 1
function [1:0] tgt;
    input [2:0] e;
    begin
        case (e)
            `ACBS_E_DUP: tgt = `ACBS_T_MDU1;
            `ACBS_E_CBW: tgt = `ACBS_T_MDU1;
            `ACBS_E_CSW: tgt = `ACBS_T_MDU1;
            default:     tgt = `ACBS_T_MDU0;
        endcase
    end
endfunction

wire cn_ok = i_cn_valid & (i_cn_ctx[7:3] == 5'h00) & (tgt(i_cn_ctx[2:0]) == `ACBS_T_MDU1);

// ****************************************
// completion notice and status decode
// ****************************************
// context names the finished request
wire        cn_cbw   = cn_ok & (i_cn_ctx[2:0] == `ACBS_E_CBW);
// spare buffer back from the engine
wire        cn_dup   = cn_ok & (i_cn_ctx[2:0] == `ACBS_E_DUP);
// status wrapper read by the host
wire        cn_csw   = cn_ok & (i_cn_ctx[2:0] == `ACBS_E_CSW);
// count empty, card done, writer idle
wire        csw_go   = ~ep_on & ack_reg & ~cw_busy_reg;
// last byte of the status write
wire        cw_last  = (cw_reg == `ACBS_CSW_IDX + `ACBS_CBW_LEN - 6'h01);
// requests on a disabled endpoint are dropped
wire        ep0_take = i_ep0_req & ep_on;
// command decode cycle, clears a stale card ack
wire        dec_now  = en & (state_reg == S_DEC);

// status signature, split into bytes on purpose
localparam [31:0] CSW_SIG = `ACBS_CSW_SIG;

// ****************************************
// card acknowledge
// ****************************************
// ack latched, cleared when a new command decodes
always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
        ack_reg <= 1'b0;
    end else if (dec_now) begin
        ack_reg <= 1'b0;
    end else if (i_card_ack) begin
        ack_reg <= 1'b1;
    end
end

// ****************************************
// wrapper memory
// ****************************************
// internal wrapper memory
always @(posedge i_clk) begin
    if (cw_busy_reg) begin
        // offset within the 32-byte status wrapper
        case (cw_reg[4:0])
            5'h00: mem[cw_reg] <= CSW_SIG[7:0];
            5'h01: mem[cw_reg] <= CSW_SIG[15:8];
            5'h02: mem[cw_reg] <= CSW_SIG[23:16];
            5'h03: mem[cw_reg] <= CSW_SIG[31:24];
            5'h04: mem[cw_reg] <= mem[4];
            5'h05: mem[cw_reg] <= mem[5];
            5'h06: mem[cw_reg] <= mem[6];
            5'h07: mem[cw_reg] <= mem[7];
            default: mem[cw_reg] <= 8'h00;
        endcase
    end else if (i_mem_wr) begin
        // the two ranges cover all 64 bytes, so any address is written
        if (i_mem_addr >= `ACBS_CSW_IDX || i_mem_addr <= `ACBS_CBW_MAX)
            mem[i_mem_addr] <= i_mem_wdata;
    end
end

// ****************************************
// wrapper memory read port
// ****************************************
// one cycle late, like a plain ram
always @(posedge i_clk) begin
    o_mem_rdata <= mem[i_mem_addr];
end

// ****************************************
// apb slave
// ****************************************
always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
        ctrl_reg <= `ACBS_CTRL_RST;
        prdata   <= 32'h0000_0000;
        pready   <= 1'b0;
        pslverr  <= 1'b0;
    end else begin
        pready  <= apb_acc;
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
        if (apb_acc) begin
            case (paddr)
                `ACBS_CTRL_OFF: begin
                    if (pwrite)
                        ctrl_reg <= pwdata;
                    prdata <= ctrl_reg;
                end
                `ACBS_STAT_OFF: prdata <= {ovr_reg, ack_reg, ep_on, dir_in_reg,
                                           17'h0_0000, state_reg};
                `ACBS_CNT_OFF:  prdata <= cnt_reg;
                `ACBS_LEN_OFF:  prdata <= len_reg;
                default:        pslverr <= 1'b1;
            endcase
        end
    end
end

// ****************************************
// sequencer
// ****************************************
always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
        state_reg      <= S_IDLE;
        cnt_reg        <= 32'h0000_0000;
        len_reg        <= 32'h0000_0000;
        dir_in_reg     <= 1'b0;
        ovr_reg        <= 1'b0;
        nbuf_reg       <= 2'h0;
        idx_reg        <= 2'h0;
        cw_reg         <= 6'h00;
        cw_busy_reg    <= 1'b0;
        o_wq_valid     <= 1'b0;
        o_wq_addr      <= 12'h000;
        o_wq_data      <= 8'h00;
        o_flush        <= 1'b0;
        o_flush_addr   <= 12'h000;
        o_ep0_cn_valid <= 1'b0;
        o_ep0_cn_ctx   <= 8'h00;
        o_error        <= 1'b0;
    end else begin
        o_wq_valid     <= 1'b0;
        o_flush        <= 1'b0;
        o_ep0_cn_valid <= 1'b0;
        o_error        <= ovr_reg;
        if (ep0_take) begin
            // count down by unit, zero disables
            cnt_reg <= (cnt_reg > `ACBS_UNIT) ? cnt_reg - `ACBS_UNIT : 32'h0000_0000;
            o_ep0_cn_valid <= 1'b1;
            o_ep0_cn_ctx   <= i_ep0_ctx;
        end
        // status writer steps one byte a cycle
        if (cw_busy_reg) begin
            // hold the last index so the writer is not started again
            if (cw_last)
                cw_busy_reg <= 1'b0;
            else
                cw_reg <= cw_reg + 6'h01;
        end
        if (!en) begin
            state_reg <= S_IDLE;
            ovr_reg   <= 1'b0;
        end else begin
            case (state_reg)
                // queues purged by software before enable
                S_IDLE: begin
                    idx_reg   <= 2'h0;
                    state_reg <= S_PCBW;
                end
                S_PCBW: begin
                    // two buffers on the out queue
                    o_wq_valid <= 1'b1;
                    o_wq_addr  <= `ACBS_SIE_OUT_Q;
                    if (idx_reg == 2'h0) begin
                        o_wq_data <= `ACBS_QE_LAST | {5'h00, `ACBS_E_CBW};
                        idx_reg   <= 2'h1;
                    end else begin
                        o_wq_data <= {5'h00, `ACBS_E_DUP};
                        state_reg <= S_WCBW;
                    end
                end
                S_WCBW: begin
                    if (cn_cbw) begin
                        if (i_cn_overrun) begin
                            ovr_reg   <= 1'b1;
                            state_reg <= S_ERR;
                        end else
                            state_reg <= S_DEC;
                    end
                end
                S_DEC: begin
                    len_reg    <= len_w;
                    cnt_reg    <= len_w;
                    dir_in_reg <= mem[12][7];
                    idx_reg    <= 2'h0;
                    // at most one buffer per sector
                    nbuf_reg   <= (sect_w > 32'h0000_0003) ? `ACBS_NBUF : sect_w[1:0];
                    if (len_w == 32'h0000_0000)
                        state_reg <= S_WDONE;
                    else if (mem[12][7])
                        state_reg <= S_IFL;
                    else
                        state_reg <= S_ODUP;
                end
                S_ODUP: begin
                    if (cn_dup) begin
                        o_wq_valid <= 1'b1;
                        o_wq_addr  <= `ACBS_MDU_RD_Q;
                        o_wq_data  <= {5'h00, `ACBS_E_BUFA};
                        idx_reg    <= 2'h1;
                        state_reg  <= S_OPOST;
                    end
                end
                S_OPOST: begin
                    if (idx_reg >= nbuf_reg)
                        state_reg <= S_WDONE;
                    else begin
                        o_wq_valid <= 1'b1;
                        o_wq_addr  <= `ACBS_SIE_OUT_Q;
                        o_wq_data  <= {6'h00, idx_reg} + 8'h01;
                        idx_reg    <= idx_reg + 2'h1;
                    end
                end
                S_IFL: begin
                    o_flush      <= 1'b1;
                    o_flush_addr <= `ACBS_SIE_OUT_Q;
                    state_reg    <= S_IPOST;
                end
                S_IPOST: begin
                    if (idx_reg >= nbuf_reg)
                        state_reg <= S_WDONE;
                    else begin
                        o_wq_valid <= 1'b1;
                        o_wq_addr  <= `ACBS_MDU_WR_Q;
                        o_wq_data  <= {6'h00, idx_reg} + 8'h01;
                        idx_reg    <= idx_reg + 2'h1;
                    end
                end
                S_WDONE: begin
                    // zero count and card ack first
                    if (csw_go) begin
                        if (cw_reg == 6'h00) begin
                            cw_reg      <= `ACBS_CSW_IDX;
                            cw_busy_reg <= 1'b1;
                        end else begin
                            o_wq_valid <= 1'b1;
                            o_wq_addr  <= `ACBS_SIE_IN_Q;
                            o_wq_data  <= `ACBS_QE_LAST | {5'h00, `ACBS_E_CSW};
                            state_reg  <= S_WCSW;
                        end
                    end
                end
                S_WCSW: begin
                    if (cn_csw) begin
                        cw_reg    <= 6'h00;
                        idx_reg   <= 2'h0;
                        state_reg <= S_PCBW;
                    end
                end
                S_ERR: state_reg <= S_ERR;
                default: state_reg <= S_IDLE;
            endcase
        end
    end
end

endmodule // acbs_seq

// >>> bench/acbs_seq_asserts.sv
// concurrent checks on the command block sequencer ports
`timescale 1ns/1ps
module acbs_seq_asserts (
    input logic        i_clk,
    input logic        i_sys_rst,
    input logic        i_cn_valid,
    input logic        i_cn_overrun,
    input logic [7:0]  i_cn_ctx,
    input logic        i_ep0_req,
    input logic [7:0]  i_ep0_ctx,
    input logic        o_wq_valid,
    input logic [11:0] o_wq_addr,
    input logic [7:0]  o_wq_data,
    input logic        o_flush,
    input logic [11:0] o_flush_addr,
    input logic        o_ep0_cn_valid,
    input logic [7:0]  o_ep0_cn_ctx,
    input logic        o_error
);
    // ****************
    // checks
    // ****************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    logic ovr_seen_reg;
    wire  post_out = o_wq_valid && o_wq_addr == 12'h190;
    always @(posedge i_clk or posedge i_sys_rst)
        if (i_sys_rst) ovr_seen_reg <= 1'b0;
        else if (i_cn_valid && i_cn_overrun) ovr_seen_reg <= 1'b1;
    chk_cmd_elem_queue: assert property (
        o_wq_valid && o_wq_data == 8'h80 |-> o_wq_addr == 12'h190)
        else $error("command element on wrong queue");
    chk_cmd_spare_pair: assert property (
        post_out && o_wq_data == 8'h80 |=> post_out && o_wq_data == 8'h05)
        else $error("spare element missing after command element");
    chk_out_repost: assert property (
        o_wq_valid && o_wq_addr == 12'h010 |-> o_wq_data == 8'h01)
        else $error("repost not on primary entry");
    chk_ep0_answer: assert property (
        o_ep0_cn_valid |-> $past(i_ep0_req) && o_ep0_cn_ctx == $past(i_ep0_ctx))
        else $error("ep0 notice without request");
    chk_flush_target: assert property (
        o_flush |-> o_flush_addr == 12'h190 ##[1:4] (o_wq_valid && o_wq_addr == 12'h014))
        else $error("flush target or media post wrong");
    chk_status_elem: assert property (
        o_wq_valid && o_wq_addr == 12'h194 |-> o_wq_data == 8'h84)
        else $error("status element value wrong");
    chk_status_restart: assert property (
        o_wq_valid && o_wq_addr == 12'h194 ##[1:300] (i_cn_valid && i_cn_ctx == 8'h04)
        |-> ##[1:4] (post_out && o_wq_data == 8'h80))
        else $error("no restart after status notice");
    chk_error_quiet: assert property (
        o_error |-> !o_wq_valid && !o_flush)
        else $error("activity during error");
    chk_error_cause: assert property (
        $rose(o_error) |-> ovr_seen_reg)
        else $error("error without overrun");
    cover property (o_flush);
    cover property (o_error);
    cover property (o_wq_valid && o_wq_addr == 12'h194);
endmodule // acbs_seq_asserts

bind acbs_seq acbs_seq_asserts u_chk (.*);

// >>> bench/acbs_far_model.sv
// usb engine and media unit model facing the sequencer
`timescale 1ns/1ps
module acbs_far_model (
    input  logic        i_clk,
    input  logic        i_sys_rst,
    input  logic        i_arm,
    input  logic        i_in_dir,
    input  logic        i_ovr,
    input  logic [31:0] i_len,
    input  logic        i_wq_valid,
    input  logic [11:0] i_wq_addr,
    input  logic [7:0]  i_wq_data,
    input  logic        i_ep0_cn_valid,
    input  logic [7:0]  i_ep0_cn_ctx,
    output logic        o_mem_wr,
    output logic [5:0]  o_mem_addr,
    output logic [7:0]  o_mem_wdata,
    output logic        o_cn_valid,
    output logic [7:0]  o_cn_ctx,
    output logic        o_cn_overrun,
    output logic        o_ep0_req,
    output logic [7:0]  o_ep0_ctx,
    output logic        o_card_ack
);
    // ****************
    // queues and fill
    // ****************
    logic [7:0] cn_q[$];
    logic [7:0] ep_q[$];
    logic       armed, pend, fill;
    logic [5:0] idx;
    logic [2:0] tick;
    function automatic logic [7:0] cbw(input logic [5:0] a);
        logic [31:0] s;
        s = i_len >> {a[1:0], 3'b000};
        cbw = (a[5:2] == 4'h2) ? s[7:0] : (a == 6'd12) ? {i_in_dir, 7'h00} :
              (a == 6'd4) ? 8'h3C : 8'h00;
    endfunction
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            {armed, pend, fill, o_mem_wr, o_cn_valid, o_cn_overrun} <= 6'h00;
            {o_ep0_req, o_card_ack, idx, tick} <= 11'h000;
            {o_mem_addr, o_mem_wdata, o_cn_ctx, o_ep0_ctx} <= 30'h0000_0000;
            cn_q.delete();
            ep_q.delete();
        end else begin
            {o_cn_valid, o_ep0_req, o_card_ack, o_mem_wr} <= 4'h0;
            // released lines do not hold their value
            {o_mem_wdata, o_cn_ctx, o_ep0_ctx} <= ~{o_mem_wdata, o_cn_ctx, o_ep0_ctx};
            tick <= tick + 3'd1;
            if (i_arm) armed <= 1'b1;
            if (i_wq_valid) begin
                if (i_wq_data == 8'h80) pend <= 1'b1;
                else if (i_wq_addr == 12'h194) ep_q = ep_q;
                else if (i_wq_data != 8'h05) ep_q.push_back(i_wq_data);
                if (i_wq_addr == 12'h194) cn_q.push_back(8'h04);
            end
            if (i_ep0_cn_valid) ep_q.push_back(i_ep0_cn_ctx);
            if (pend && armed && !fill) begin
                {fill, pend, armed, idx} <= 9'h100;
            end
            if (fill) begin
                o_mem_wr <= 1'b1;
                o_mem_addr <= idx;
                o_mem_wdata <= cbw(idx);
                idx <= idx + 6'd1;
                if (idx == (i_ovr ? 6'd30 : 6'd31)) begin
                    fill <= 1'b0;
                    cn_q.push_back(8'h00);
                    if (!i_ovr && !i_in_dir) cn_q.push_back(8'h05);
                end
            end
            if (tick == 3'd0 && cn_q.size() != 0) begin
                o_cn_valid <= 1'b1;
                o_cn_ctx <= cn_q.pop_front();
                o_cn_overrun <= i_ovr;
            end
            if (tick == 3'd4 && ep_q.size() != 0) begin
                {o_ep0_req, o_card_ack} <= 2'b11;
                o_ep0_ctx <= ep_q.pop_front();
            end
        end
    end
endmodule // acbs_far_model

// >>> bench/tb_top.sv
// self-checking bench for the command block sequencer
`timescale 1ns/1ps
module tb_top;
    // ****************
    // signals
    // ****************
    logic        i_clk = 1'b0, i_sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, len = 32'h0000_0000;
    logic        arm = 1'b0, in_dir = 1'b0, ovr = 1'b0;
    logic [5:0]  rd_addr = 6'h00;
    wire  [31:0] prdata;
    wire  [11:0] wq_addr, fl_addr;
    wire  [7:0]  wq_data, mem_wd, mem_rd, cn_ctx, ep_ctx, ep_cn_ctx;
    wire  [5:0]  p_addr;
    wire         pready, pslverr, mem_wr, cn_v, cn_ovr, ep_req, ack, wq_v, fl, ep_cn_v, err;
    logic [19:0] log_q[$];
    int          err_total = 0, compares = 0, ep0_cns = 0;
    always #12.5 i_clk = ~i_clk;
    acbs_seq dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .i_cn_valid(cn_v), .i_cn_ctx(cn_ctx), .i_cn_overrun(cn_ovr),
        .i_mem_wr(mem_wr), .i_mem_addr(mem_wr ? p_addr : rd_addr), .i_mem_wdata(mem_wd),
        .o_mem_rdata(mem_rd), .i_ep0_req(ep_req), .i_ep0_ctx(ep_ctx), .i_card_ack(ack),
        .o_wq_valid(wq_v), .o_wq_addr(wq_addr), .o_wq_data(wq_data), .o_flush(fl),
        .o_flush_addr(fl_addr), .o_ep0_cn_valid(ep_cn_v), .o_ep0_cn_ctx(ep_cn_ctx),
        .o_error(err));
    acbs_far_model far (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_arm(arm), .i_in_dir(in_dir),
        .i_ovr(ovr), .i_len(len), .i_wq_valid(wq_v), .i_wq_addr(wq_addr), .i_wq_data(wq_data),
        .i_ep0_cn_valid(ep_cn_v), .i_ep0_cn_ctx(ep_cn_ctx), .o_mem_wr(mem_wr),
        .o_mem_addr(p_addr), .o_mem_wdata(mem_wd), .o_cn_valid(cn_v), .o_cn_ctx(cn_ctx),
        .o_cn_overrun(cn_ovr), .o_ep0_req(ep_req), .o_ep0_ctx(ep_ctx), .o_card_ack(ack));
    always @(posedge i_clk) begin
        if (wq_v) log_q.push_back({wq_addr, wq_data});
        if (fl) log_q.push_back({fl_addr, 8'hFF});
        if (ep_cn_v) ep0_cns++;
    end
    // ****************
    // helpers
    // ****************
    task automatic check(input string what, input logic [31:0] exp, got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n = 0;
        @(posedge i_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge i_clk);
        penable <= 1'b1;
        do begin @(posedge i_clk); n++; end while (pready !== 1'b1 && n < 50);
        {q, e} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task automatic expect_list(input string what, input logic [19:0] v[$]);
        int n;
        foreach (v[i]) begin
            for (n = 0; log_q.size() == 0 && n < 3000; n++) @(posedge i_clk);
            check(what, v[i], log_q.size() != 0 ? log_q.pop_front() : 32'hxxxx_xxxx);
        end
    endtask
    task automatic go(input logic [31:0] l, input logic d, o);
        repeat (60) @(posedge i_clk);
        {len, in_dir, ovr, arm, ep0_cns} <= {l, d, o, 1'b1, 32'h0};
        @(posedge i_clk);
        arm <= 1'b0;
    endtask
    task automatic tally_and_finish;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic scen_regs;
        logic [31:0] q;
        logic        e;
        apb(1'b0, 12'h004, 32'h0, q, e);
        check("idle status", 32'h0000_0001, q);
        apb(1'b1, 12'h040, 32'hFFFF_FFFF, q, e);
        check("unmapped refused", 32'h1, e);
        apb(1'b1, 12'h000, 32'h0000_0001, q, e);
        expect_list("command posts", '{20'h190_80, 20'h190_05});
    endtask
    task automatic scen_out;
        logic [31:0] q;
        logic        e;
        go(32'd1536, 1'b0, 1'b0);
        expect_list("out data posts", '{20'h010_01, 20'h190_02, 20'h190_03});
        expect_list("out status posts", '{20'h194_84, 20'h190_80, 20'h190_05});
        check("out ep0 notices", 32'd3, ep0_cns);
        apb(1'b0, 12'h008, 32'h0, q, e);
        check("out byte count", 32'h0, q);
        foreach (q[i]) if (i < 2) begin
            rd_addr <= i ? 6'd36 : 6'd32;
            repeat (3) @(posedge i_clk);
            check("status wrapper byte", i ? 8'h3C : 8'h55, mem_rd);
        end
    endtask
    task automatic scen_in;
        go(32'd512, 1'b1, 1'b0);
        expect_list("in posts", '{20'h190_FF, 20'h014_01});
        expect_list("in status posts", '{20'h194_84, 20'h190_80, 20'h190_05});
        check("in ep0 notices", 32'd1, ep0_cns);
    endtask
    task automatic scen_ovr;
        logic [31:0] q;
        logic        e;
        go(32'd1024, 1'b0, 1'b1);
        for (int n = 0; err !== 1'b1 && n < 2000; n++) @(posedge i_clk);
        check("error flag", 32'h1, err);
        apb(1'b0, 12'h004, 32'h0, q, e);
        check("overrun bit", 32'h1, q[31]);
        repeat (100) @(posedge i_clk);
        check("posts after overrun", 32'h0, log_q.size());
        apb(1'b1, 12'h000, 32'h0, q, e);
        repeat (3) @(posedge i_clk);
        check("error cleared", 32'h0, err);
    endtask
    initial begin
        repeat (5) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        scen_regs;
        scen_out;
        scen_in;
        scen_ovr;
        tally_and_finish;
    end
    initial begin
        #1_000_000;
        err_total++;
        tally_and_finish;
    end
endmodule // tb_top
